// ===== hw/io_expander_pkg.sv
`default_nettype none
package io_expander_pkg;

	// ==========================================================================
	// Geometry
	// ==========================================================================
	localparam int PIN_W  = 8;
	localparam int NPORT  = 2;
	localparam int ADDR_W = 5;

	// ==========================================================================
	// Register indices within one port
	// ==========================================================================
	localparam logic [3:0] REG_DIRECTION = 4'h0;
	localparam logic [3:0] REG_POLARITY  = 4'h1;
	localparam logic [3:0] REG_IRQ_EN    = 4'h2;
	localparam logic [3:0] REG_DEFAULT   = 4'h3;
	localparam logic [3:0] REG_CMP_SEL   = 4'h4;
	localparam logic [3:0] REG_CONFIG    = 4'h5;
	localparam logic [3:0] REG_PULLUP    = 4'h6;
	localparam logic [3:0] REG_FLAG      = 4'h7;
	localparam logic [3:0] REG_CAPTURE   = 4'h8;
	localparam logic [3:0] REG_VALUE     = 4'h9;
	localparam logic [3:0] REG_LATCH     = 4'hA;

	// Segregated bank mode places port B at this base.
	localparam logic [4:0] BANK_B_BASE = 5'h10;

	// ==========================================================================
	// Configuration register fields
	// ==========================================================================
	localparam int CFG_BANK         = 7;
	localparam int CFG_MIRROR       = 6;
	localparam int CFG_AUTOINC_DIS  = 5;
	localparam int CFG_SLEW_OFF     = 4;
	localparam int CFG_HW_ADDR      = 3;
	localparam int CFG_OPEN_DRAIN   = 2;
	localparam int CFG_ACTIVE_LEVEL = 1;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hFE;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [7:0] DIRECTION_RESET = 8'hFF;
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [4:0] PTR_RESET       = 5'h00;

	// ==========================================================================
	// Link operations and the request word that crosses to the core
	// ==========================================================================
	typedef enum logic [1:0] {
		OP_ADDR      = 2'b00,
		OP_WRITE     = 2'b01,
		OP_READ      = 2'b10,
		OP_READ_DONE = 2'b11
	} link_op_t;

	typedef enum logic {
		LS_IDLE = 1'b0,
		LS_WAIT = 1'b1
	} link_state_t;

	typedef struct packed {
		link_op_t          op;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} link_req_t;

endpackage
`default_nettype wire

// ===== hw/io_expander_port_irq_logic.sv
`timescale 1ns/1ps
`default_nettype none
module io_expander_port_irq_logic (
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	input  wire logic                         link_clk,
	input  wire logic                         link_op_valid,
	input  wire io_expander_pkg::link_op_t    link_op,
	input  wire logic [7:0]                   link_op_data,
	output logic                              link_busy,
	output logic                              link_rd_valid,
	output logic [7:0]                        link_rd_data,
	input  wire logic [15:0]                  pin_in,
	output logic [15:0]                       pin_out,
	output logic [15:0]                       pin_oe,
	output logic [15:0]                       pin_pullup_en,
	output logic                              irq_out_port_a_o,
	output logic                              irq_out_port_a_oe,
	output logic                              irq_out_port_b_o,
	output logic                              irq_out_port_b_oe,
	output logic                              sda_slew_limit_off,
	output logic                              hw_addr_pins_enable
);

	// ==========================================================================
	// Address decoding
	// ==========================================================================

	// Maps a pointer to {valid, port, index}; the bank bit picks the layout.
	function automatic logic [5:0] decode_addr(input logic [4:0] addr, input logic bank);
		logic       ok;
		logic       port;
		logic [3:0] idx;
		ok   = 1'b0;
		port = 1'b0;
		idx  = 4'h0;
		if (bank)
		begin
			port = addr[4];
			idx  = addr[3:0];
			ok   = (addr[3:0] <= io_expander_pkg::REG_LATCH);
		end
		else
		begin
			port = addr[0];
			idx  = addr[4:1];
			ok   = (addr[4:1] <= io_expander_pkg::REG_LATCH);
		end
		return {ok, port, idx};
	endfunction

	// ==========================================================================
	// Link domain: pointer and request handshake
	// ==========================================================================
	io_expander_pkg::link_state_t link_state_q;
	io_expander_pkg::link_req_t   req_q;
	logic [4:0]                   ptr_q;
	logic                         req_tgl_q;
	logic                         ack_s1_q;
	logic                         ack_s2_q;
	logic                         ack_s3_q;
	logic                         ainc_s1_q;
	logic                         ainc_s2_q;
	logic                         link_busy_q;
	logic                         link_rd_valid_q;
	logic [7:0]                   link_rd_data_q;

	// Core-side signals that the link side reads through the handshake.
	logic                         ack_tgl_q;
	logic [7:0]                   rd_data_q;
	logic [7:0]                   cfg_q;

	// Acknowledge toggle and the auto-increment disable level cross by two flops.
	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_s1_q  <= 1'b0;
			ack_s2_q  <= 1'b0;
			ack_s3_q  <= 1'b0;
			ainc_s1_q <= 1'b0;
			ainc_s2_q <= 1'b0;
		end
		else
		begin
			ack_s1_q  <= ack_tgl_q;
			ack_s2_q  <= ack_s1_q;
			ack_s3_q  <= ack_s2_q;
			ainc_s1_q <= cfg_q[io_expander_pkg::CFG_AUTOINC_DIS];
			ainc_s2_q <= ainc_s1_q;
		end
	end

	// One request is in flight at a time; ops offered while busy are dropped.
	// The request word stays still until the acknowledge returns, so the core
	// may sample it directly once it sees the toggle.
	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_state_q    <= io_expander_pkg::LS_IDLE;
			req_q           <= '0;
			ptr_q           <= io_expander_pkg::PTR_RESET;
			req_tgl_q       <= 1'b0;
			link_busy_q     <= 1'b0;
			link_rd_valid_q <= 1'b0;
			link_rd_data_q  <= io_expander_pkg::REG_RESET;
		end
		else
		begin
			link_rd_valid_q <= 1'b0;
			case (link_state_q)
				io_expander_pkg::LS_IDLE:
				begin
					if (link_op_valid)
					begin
						if (link_op == io_expander_pkg::OP_ADDR)
						begin
							ptr_q <= link_op_data[4:0];
						end
						else
						begin
							req_q.op     <= link_op;
							req_q.addr   <= ptr_q;
							req_q.data   <= link_op_data;
							req_tgl_q    <= ~req_tgl_q;
							link_busy_q  <= 1'b1;
							link_state_q <= io_expander_pkg::LS_WAIT;
							// The pointer moves after each whole byte unless held.
							if (link_op != io_expander_pkg::OP_READ && !ainc_s2_q)
							begin
								ptr_q <= ptr_q + 5'h01;
							end
						end
					end
				end
				io_expander_pkg::LS_WAIT:
				begin
					if (ack_s2_q ^ ack_s3_q)
					begin
						link_busy_q     <= 1'b0;
						link_state_q    <= io_expander_pkg::LS_IDLE;
						link_rd_valid_q <= (req_q.op == io_expander_pkg::OP_READ);
						link_rd_data_q  <= rd_data_q;
					end
				end
				default:
				begin
					link_state_q <= io_expander_pkg::LS_IDLE;
					link_busy_q  <= 1'b0;
				end
			endcase
		end
	end

	assign link_busy     = link_busy_q;
	assign link_rd_valid = link_rd_valid_q;
	assign link_rd_data  = link_rd_data_q;

	// ==========================================================================
	// Core domain: request receipt and decode
	// ==========================================================================
	logic       req_s1_q;
	logic       req_s2_q;
	logic       req_s3_q;
	logic       req_evt;
	logic [5:0] dec;
	logic       dec_ok;
	logic       dec_port;
	logic [3:0] dec_idx;
	logic       wr_en;
	logic [1:0] clr;

	// Request toggle synchroniser; the edge detector looks only past the second flop.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
		end
		else
		begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	// Decoding uses the live bank bit, so a byte that flips it remaps the next one.
	assign req_evt  = req_s2_q ^ req_s3_q;
	assign dec      = decode_addr(req_q.addr, cfg_q[io_expander_pkg::CFG_BANK]);
	assign dec_ok   = dec[5];
	assign dec_port = dec[4];
	assign dec_idx  = dec[3:0];
	assign wr_en    = req_evt && dec_ok && (req_q.op == io_expander_pkg::OP_WRITE);

	// ==========================================================================
	// Core domain: per-port registers and interrupt logic
	// ==========================================================================
	logic [7:0] dir_q  [2];
	logic [7:0] pol_q  [2];
	logic [7:0] ien_q  [2];
	logic [7:0] def_q  [2];
	logic [7:0] csel_q [2];
	logic [7:0] pu_q   [2];
	logic [7:0] lat_q  [2];
	logic [7:0] flag_q [2];
	logic [7:0] cap_q  [2];
	logic [7:0] ref_q  [2];
	logic [7:0] pin_q  [2];
	logic [7:0] val    [2];
	logic [1:0] pend_q;
	logic [7:0] pin_s1_q [2];

	genvar gp;
	generate
		for (gp = 0; gp < io_expander_pkg::NPORT; gp++)
		begin : g_port
			logic [7:0] cond;
			logic [7:0] cond_after_clr;

			// Pins come from outside and pass two flops before use.
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pin_s1_q[gp] <= io_expander_pkg::REG_RESET;
					pin_q[gp]    <= io_expander_pkg::REG_RESET;
				end
				else
				begin
					pin_s1_q[gp] <= pin_in[gp*8 +: 8];
					pin_q[gp]    <= pin_s1_q[gp];
				end
			end

			// Port value as software sees it, after polarity inversion.
			assign val[gp] = pin_q[gp] ^ pol_q[gp];

			// Host writes; flag and capture take none, value writes land in the latch.
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					dir_q[gp]  <= io_expander_pkg::DIRECTION_RESET;
					pol_q[gp]  <= io_expander_pkg::REG_RESET;
					ien_q[gp]  <= io_expander_pkg::REG_RESET;
					def_q[gp]  <= io_expander_pkg::REG_RESET;
					csel_q[gp] <= io_expander_pkg::REG_RESET;
					pu_q[gp]   <= io_expander_pkg::REG_RESET;
					lat_q[gp]  <= io_expander_pkg::REG_RESET;
				end
				else if (wr_en && (dec_port == 1'(gp)))
				begin
					case (dec_idx)
						io_expander_pkg::REG_DIRECTION: dir_q[gp]  <= req_q.data;
						io_expander_pkg::REG_POLARITY:  pol_q[gp]  <= req_q.data;
						io_expander_pkg::REG_IRQ_EN:    ien_q[gp]  <= req_q.data;
						io_expander_pkg::REG_DEFAULT:   def_q[gp]  <= req_q.data;
						io_expander_pkg::REG_CMP_SEL:   csel_q[gp] <= req_q.data;
						io_expander_pkg::REG_PULLUP:    pu_q[gp]   <= req_q.data;
						io_expander_pkg::REG_VALUE:     lat_q[gp]  <= req_q.data;
						io_expander_pkg::REG_LATCH:     lat_q[gp]  <= req_q.data;
						default:                        lat_q[gp]  <= lat_q[gp];
					endcase
				end
			end

			// A pin counts only as an enabled input; the select bit picks the reference.
			assign cond = ien_q[gp] & dir_q[gp]
				& ((csel_q[gp] & (pin_q[gp] ^ def_q[gp]))
				| (~csel_q[gp] & (pin_q[gp] ^ ref_q[gp])));
			// At a clear the reference becomes the pin, so only default mismatches remain.
			assign cond_after_clr = ien_q[gp] & dir_q[gp] & csel_q[gp] & (pin_q[gp] ^ def_q[gp]);

			// Interrupt state. A default mismatch in the clearing cycle wins and
			// re-raises at once with a fresh capture, which is why the capture
			// should be read before the value register.
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pend_q[gp] <= 1'b0;
					flag_q[gp] <= io_expander_pkg::REG_RESET;
					cap_q[gp]  <= io_expander_pkg::REG_RESET;
					ref_q[gp]  <= io_expander_pkg::REG_RESET;
				end
				else if (clr[gp])
				begin
					ref_q[gp] <= pin_q[gp];
					if (|cond_after_clr)
					begin
						pend_q[gp] <= 1'b1;
						flag_q[gp] <= cond_after_clr;
						cap_q[gp]  <= val[gp];
					end
					else
					begin
						pend_q[gp] <= 1'b0;
						flag_q[gp] <= io_expander_pkg::REG_RESET;
					end
				end
				else if (!pend_q[gp])
				begin
					ref_q[gp] <= pin_q[gp];
					if (|cond)
					begin
						pend_q[gp] <= 1'b1;
						flag_q[gp] <= cond;
						cap_q[gp]  <= val[gp];
					end
				end
			end

			// A clear needs the finished read of this port's value or capture.
			assign clr[gp] = req_evt && dec_ok && (dec_port == 1'(gp))
				&& (req_q.op == io_expander_pkg::OP_READ_DONE)
				&& (dec_idx == io_expander_pkg::REG_VALUE || dec_idx == io_expander_pkg::REG_CAPTURE);

			// Pin drive and pull-ups; pull-ups only where the pin is an input.
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pin_oe[gp*8 +: 8]        <= io_expander_pkg::REG_RESET;
					pin_pullup_en[gp*8 +: 8] <= io_expander_pkg::REG_RESET;
				end
				else
				begin
					pin_oe[gp*8 +: 8]        <= ~dir_q[gp];
					pin_pullup_en[gp*8 +: 8] <= pu_q[gp] & dir_q[gp];
				end
			end

			assign pin_out[gp*8 +: 8] = lat_q[gp];
		end
	endgenerate

	// ==========================================================================
	// Core domain: configuration, read data and acknowledge
	// ==========================================================================

	// The configuration register is shared; both ports' copies hit this one.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_q <= io_expander_pkg::REG_RESET;
		end
		else if (wr_en && dec_idx == io_expander_pkg::REG_CONFIG)
		begin
			cfg_q <= req_q.data & io_expander_pkg::CFG_WRITE_MASK;
		end
	end

	// Read data is latched in the same cycle as the acknowledge toggles, so it is stable
	// by the time the link side picks it up.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data_q <= io_expander_pkg::REG_RESET;
			ack_tgl_q <= 1'b0;
		end
		else if (req_evt)
		begin
			ack_tgl_q <= ~ack_tgl_q;
			if (req_q.op == io_expander_pkg::OP_READ)
			begin
				if (!dec_ok)
				begin
					rd_data_q <= io_expander_pkg::REG_RESET;
				end
				else
				begin
					case (dec_idx)
						io_expander_pkg::REG_DIRECTION: rd_data_q <= dir_q[dec_port];
						io_expander_pkg::REG_POLARITY:  rd_data_q <= pol_q[dec_port];
						io_expander_pkg::REG_IRQ_EN:    rd_data_q <= ien_q[dec_port];
						io_expander_pkg::REG_DEFAULT:   rd_data_q <= def_q[dec_port];
						io_expander_pkg::REG_CMP_SEL:   rd_data_q <= csel_q[dec_port];
						io_expander_pkg::REG_CONFIG:    rd_data_q <= cfg_q;
						io_expander_pkg::REG_PULLUP:    rd_data_q <= pu_q[dec_port];
						io_expander_pkg::REG_FLAG:      rd_data_q <= flag_q[dec_port];
						io_expander_pkg::REG_CAPTURE:   rd_data_q <= cap_q[dec_port];
						io_expander_pkg::REG_VALUE:     rd_data_q <= val[dec_port];
						io_expander_pkg::REG_LATCH:     rd_data_q <= lat_q[dec_port];
						default:                        rd_data_q <= io_expander_pkg::REG_RESET;
					endcase
				end
			end
		end
	end

	// ==========================================================================
	// Interrupt pads and configuration outputs
	// ==========================================================================
	logic act_a;
	logic act_b;

	// With mirroring each pad shows the OR, yet each port still clears alone.
	assign act_a = pend_q[0] | (cfg_q[io_expander_pkg::CFG_MIRROR] & pend_q[1]);
	assign act_b = pend_q[1] | (cfg_q[io_expander_pkg::CFG_MIRROR] & pend_q[0]);

	// Open drain pulls low only when active and overrides the level bit.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_out_port_a_o  <= 1'b1;
			irq_out_port_a_oe <= 1'b1;
			irq_out_port_b_o  <= 1'b1;
			irq_out_port_b_oe <= 1'b1;
		end
		else if (cfg_q[io_expander_pkg::CFG_OPEN_DRAIN])
		begin
			irq_out_port_a_o  <= 1'b0;
			irq_out_port_a_oe <= act_a;
			irq_out_port_b_o  <= 1'b0;
			irq_out_port_b_oe <= act_b;
		end
		else
		begin
			irq_out_port_a_o  <= ~(act_a ^ cfg_q[io_expander_pkg::CFG_ACTIVE_LEVEL]);
			irq_out_port_a_oe <= 1'b1;
			irq_out_port_b_o  <= ~(act_b ^ cfg_q[io_expander_pkg::CFG_ACTIVE_LEVEL]);
			irq_out_port_b_oe <= 1'b1;
		end
	end

	// The serial pad and the address matcher live elsewhere; they take these levels.
	// The address matcher ignores this level on the two-wire variant.
	assign sda_slew_limit_off  = cfg_q[io_expander_pkg::CFG_SLEW_OFF];
	assign hw_addr_pins_enable = cfg_q[io_expander_pkg::CFG_HW_ADDR];

endmodule
`default_nettype wire

// ===== tb/io_expander_port_irq_logic_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checker
// ==========================================================================
module io_expander_checker (
	input wire logic                      ref_clk,
	input wire logic                      rst_n,
	input wire logic                      link_clk,
	input wire logic                      link_op_valid,
	input wire io_expander_pkg::link_op_t link_op,
	input wire logic                      link_busy,
	input wire logic                      link_rd_valid,
	input wire logic [7:0]                link_rd_data,
	input wire logic [15:0]               pin_out,
	input wire logic [15:0]               pin_oe,
	input wire logic [15:0]               pin_pullup_en,
	input wire logic                      irq_out_port_a_o,
	input wire logic                      irq_out_port_a_oe,
	input wire logic                      irq_out_port_b_o,
	input wire logic                      irq_out_port_b_oe,
	input wire logic                      sda_slew_limit_off,
	input wire logic                      hw_addr_pins_enable
);
	pullup_inputs_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(pin_pullup_en & pin_oe) == 16'h0000) else $error("pull-up on a driven pin");
	drain_a_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!irq_out_port_a_oe |-> !irq_out_port_a_o) else $error("port a pad high while released");
	drain_b_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!irq_out_port_b_oe |-> !irq_out_port_b_o) else $error("port b pad high while released");
	config_by_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$changed({pin_out, pin_oe, pin_pullup_en, sda_slew_limit_off, hw_addr_pins_enable})
		|-> link_busy || $past(link_busy)) else $error("register output moved without a write");
	busy_bounded_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		$rose(link_busy) |-> ##[1:20] !link_busy) else $error("link request never finished");
	busy_after_op_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		link_op_valid && !link_busy && link_op != io_expander_pkg::OP_ADDR |=> link_busy)
		else $error("taken op did not raise busy");
	read_ends_busy_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		link_rd_valid |-> $fell(link_busy)) else $error("read data outside completion");
	read_data_hold_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		!link_rd_valid |-> $stable(link_rd_data)) else $error("read data moved between reads");
	// Main scenarios that the bench is expected to reach.
	rd_seen_c: cover property (@(posedge link_clk) disable iff (!rst_n) link_rd_valid);
	irq_a_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq_out_port_a_o));
	drain_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(irq_out_port_b_oe));
endmodule
bind io_expander_port_irq_logic io_expander_checker chk (.ref_clk, .rst_n, .link_clk, .link_op_valid,
	.link_op, .link_busy, .link_rd_valid, .link_rd_data, .pin_out, .pin_oe, .pin_pullup_en,
	.irq_out_port_a_o, .irq_out_port_a_oe, .irq_out_port_b_o, .irq_out_port_b_oe,
	.sda_slew_limit_off, .hw_addr_pins_enable);
`default_nettype wire

// ===== tb/io_expander_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Serial host model, one byte operation at a time
// ==========================================================================
module io_expander_host_model (
	input wire logic                  link_clk,
	input wire logic                  link_busy,
	input wire logic [7:0]            link_rd_data,
	output logic                      link_op_valid,
	output io_expander_pkg::link_op_t link_op,
	output logic [7:0]                link_op_data,
	output logic                      hang
);
	// Idle values before the first operation.
	initial
	begin
		link_op_valid = 1'b0;
		link_op = io_expander_pkg::OP_ADDR;
		link_op_data = 8'h00;
		hang = 1'b0;
	end

	// The data lines are scrambled once released so stale bytes are never mistaken for live ones.
	task automatic put(input io_expander_pkg::link_op_t o, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge link_clk);
		link_op_valid <= 1'b1;
		link_op <= o;
		link_op_data <= d;
		@(posedge link_clk);
		link_op_valid <= 1'b0;
		link_op_data <= ~d;
		if (o != io_expander_pkg::OP_ADDR)
		begin
			do
			begin
				@(negedge link_clk);
				n++;
			end
			while (link_busy && n < 20);
			if (link_busy)
				hang <= 1'b1;
		end
	endtask

	// Every write reloads the pointer, so a bank change never strands a burst.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		put(io_expander_pkg::OP_ADDR, a);
		put(io_expander_pkg::OP_WRITE, d);
	endtask

	// The closing step tells the device the low bit has left the wire.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		put(io_expander_pkg::OP_ADDR, a);
		put(io_expander_pkg::OP_READ, 8'h00);
		d = link_rd_data;
		put(io_expander_pkg::OP_READ_DONE, 8'h00);
	endtask
endmodule
`default_nettype wire

// ===== tb/test_io_expander_port_irq_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_io_expander_port_irq_logic;
	logic                      ref_clk, link_clk, rst_n, link_op_valid, link_busy, link_rd_valid, hang;
	io_expander_pkg::link_op_t link_op;
	logic [7:0]                link_op_data, link_rd_data;
	logic [15:0]               pin_in, pin_out, pin_oe, pin_pullup_en;
	logic                      a_o, a_oe, b_o, b_oe, slew_off, hw_en;
	int                        fail_count, total_checks;
	logic [7:0]                rst_tab [7] = '{8'h0A, 8'h0C, 8'h0E, 8'h14, 8'h15, 8'h16, 8'h1F};

	// ==========================================================================
	// Clocks, device and host
	// ==========================================================================
	always #5 ref_clk = ~ref_clk;
	always #3 link_clk = ~link_clk;
	io_expander_port_irq_logic dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
		.link_op_valid(link_op_valid), .link_op(link_op), .link_op_data(link_op_data),
		.link_busy(link_busy), .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
		.irq_out_port_a_o(a_o), .irq_out_port_a_oe(a_oe), .irq_out_port_b_o(b_o),
		.irq_out_port_b_oe(b_oe), .sda_slew_limit_off(slew_off), .hw_addr_pins_enable(hw_en));
	io_expander_host_model host (.link_clk(link_clk), .link_busy(link_busy), .link_rd_data(link_rd_data),
		.link_op_valid(link_op_valid), .link_op(link_op), .link_op_data(link_op_data), .hang(hang));

	// ==========================================================================
	// Helpers
	// ==========================================================================
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask

	// Pin sync and pad registers need four core edges; six leaves margin on either side.
	task automatic st();
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic pins(input logic [15:0] v);
		@(posedge ref_clk);
		pin_in <= v;
		st();
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// A stuck link request ends the run through the same report.
	always @(posedge hang)
	begin
		fail_count++;
		give_verdict();
	end

	// ==========================================================================
	// Sequence, paired map: address is register index times two plus port
	// ==========================================================================
	initial
	begin
		ref_clk = 1'b0;
		link_clk = 1'b0;
		rst_n = 1'b0;
		pin_in = 16'h0000;
		fail_count = 0;
		total_checks = 0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		st();
		foreach (rst_tab[i]) rc(rst_tab[i], 8'h00);
		rc(8'h00, io_expander_pkg::DIRECTION_RESET);
		chk({slew_off, hw_en, a_o, a_oe, b_o, b_oe}, 16'h000F);
		host.wr(8'h0A, 8'h1F);
		rc(8'h0B, 8'h1E);
		st();
		chk({slew_off, hw_en, a_o, a_oe, b_o, b_oe}, 16'h0030);
		host.wr(8'h0A, 8'h02);
		st();
		chk({slew_off, hw_en, a_o, a_oe, b_o, b_oe}, 16'h0005);
		host.put(io_expander_pkg::OP_ADDR, 8'h14);
		host.put(io_expander_pkg::OP_WRITE, 8'h5A);
		host.put(io_expander_pkg::OP_WRITE, 8'hA5);
		rc(8'h15, 8'hA5);
		host.wr(8'h0A, 8'h22);
		st();
		host.put(io_expander_pkg::OP_ADDR, 8'h14);
		host.put(io_expander_pkg::OP_WRITE, 8'h11);
		host.put(io_expander_pkg::OP_WRITE, 8'h22);
		rc(8'h14, 8'h22);
		rc(8'h15, 8'hA5);
		host.wr(8'h0A, 8'h02);
		host.wr(8'h00, 8'h0F);
		host.wr(8'h0C, 8'hFF);
		host.wr(8'h12, 8'h3C);
		rc(8'h14, 8'h3C);
		chk(pin_oe, 16'h00F0);
		chk(pin_pullup_en, 16'h000F);
		chk(pin_out, 16'hA53C);
		pins(16'h0096);
		rc(8'h12, 8'h96);
		host.wr(8'h02, 8'hFF);
		rc(8'h12, 8'h69);
		host.wr(8'h02, 8'h00);
		// Previous-value compare on port B.
		host.wr(8'h05, 8'h01);
		pins(16'h0196);
		chk({a_o, b_o}, 16'h0001);
		host.wr(8'h0F, 8'hFF);
		host.wr(8'h11, 8'hFF);
		host.wr(8'h13, 8'hA5);
		rc(8'h0F, 8'h01);
		chk(b_o, 16'h0001);
		pins(16'h0096);
		rc(8'h11, 8'h01);
		st();
		chk(b_o, 16'h0000);
		rc(8'h0F, 8'h00);
		// Default compare on port B: a persisting mismatch re-raises after a read.
		host.wr(8'h09, 8'h01);
		pins(16'h0196);
		rc(8'h13, 8'h01);
		st();
		chk(b_o, 16'h0001);
		pins(16'h0096);
		rc(8'h11, 8'h01);
		st();
		chk(b_o, 16'h0000);
		// Mirrored pads with both ports pending.
		host.wr(8'h0A, 8'h42);
		host.wr(8'h04, 8'h11);
		pins(16'h0086);
		chk(a_o, 16'h0000);
		pins(16'h0087);
		chk({a_o, b_o}, 16'h0003);
		pins(16'h0187);
		rc(8'h10, 8'h87);
		st();
		chk({a_o, b_o}, 16'h0003);
		host.wr(8'h0A, 8'h46);
		st();
		chk({a_o, a_oe, b_o, b_oe}, 16'h0005);
		pins(16'h0087);
		rc(8'h11, 8'h01);
		st();
		chk({a_o, a_oe, b_o, b_oe}, 16'h0000);
		// Banked map: the byte after the bank change already decodes with the new layout.
		host.put(io_expander_pkg::OP_ADDR, 8'h0A);
		host.put(io_expander_pkg::OP_WRITE, 8'h80);
		host.put(io_expander_pkg::OP_WRITE, 8'h55);
		rc(8'h15, 8'h80);
		rc(8'h1A, 8'hA5);
		rc(8'h0A, 8'h3C);
		give_verdict();
	end
endmodule
`default_nettype wire
